// *** rtl/vos_consts.vh ***
// Purpose: constants for the video output status and control block
// Assumes: 32-bit AHB-Lite register words, byte addresses below
// Notes:   definitions only
`ifndef VOS_CONSTS_VH
`define VOS_CONSTS_VH

// register byte offsets
`define VOS_OFS_CTRL      8'h00
`define VOS_OFS_STATUS    8'h04
`define VOS_OFS_LINE      8'h08
`define VOS_OFS_MASK      8'h0C

// control word reset value and fields
`define VOS_CTRL_RESET    32'h3240_0000
`define VOS_CTRL_SWRST    31
`define VOS_CTRL_AWAKE    30
`define VOS_CTRL_CSEL_HI  29
`define VOS_CTRL_CSEL_LO  28
`define VOS_CTRL_PLLS_HI  27
`define VOS_CTRL_PLLS_LO  25
`define VOS_CTRL_PLLT_HI  24
`define VOS_CTRL_PLLT_LO  22
`define VOS_CTRL_CLKDRV   21
`define VOS_CTRL_SYNCM    20
`define VOS_CTRL_ACK2     9
`define VOS_CTRL_ACK1     8
`define VOS_CTRL_MODE_HI  3
`define VOS_CTRL_MODE_LO  1
`define VOS_CTRL_EN       0
// writable bits of the control word (acks are actions and read zero)
`define VOS_CTRL_WMASK    32'hFFF0_000F

// mode codes
`define VOS_MODE_STREAM   3'h4

// clock source codes
`define VOS_CSEL_VCO      2'h0
`define VOS_CSEL_FBDIV    2'h1
`define VOS_CSEL_INDIV    2'h2
`define VOS_CSEL_DDS      2'h3

// status bit positions
`define VOS_ST_LINE       0
`define VOS_ST_UNDERRUN_FLAG       1
`define VOS_ST_DRAIN1     2
`define VOS_ST_DRAIN2     3
`define VOS_ST_UNIT       4
`define VOS_ST_SECOND_FIELD_ACTIVE     6
`define VOS_ST_VERTICAL_BLANK_FLAG     7
`define VOS_STICKY_MASK   32'h0000_0003

// settling time after software reset, in pixel clock cycles
`define VOS_SETTLE_PIX    3'h5

`endif

// *** rtl/vos_ctrl.v ***
// Purpose: status flags, control word and AHB-Lite register slave of the video output unit
// Assumes: single clock, all pin inputs synchronous to clk
// Notes:   zero wait state slave, response always OKAY
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "vos_consts.vh"
// Operation
// - line match flag on programmed line
// - underrun flag requests interrupt when enabled
// - refresh underrun at start of video
// - first buffer ack clears drained flag
// - streaming underrun when no next buffer
// - streaming field flag shows active buffer
// - refresh field flag high in field two
// - vertical blank flag only in refresh
// - control resets to fixed documented word
// - wait five pixel clocks before enabling
// - hardware reset makes clock, sync pins inputs
// - software reset keeps registers unchanged
// - keep awake blocks global power down
// - refresh underrun if drained not acked
// - clock source field selects pixel clock
module vos_ctrl #(
  parameter [3:0] DDS_DIV  = 4'h2,
  parameter       BUF_SIZE = 64,
  parameter       H_TOTAL  = 16,
  parameter       H_ACTIVE = 12,
  parameter       V_TOTAL  = 10,
  parameter       V_ACTIVE = 8
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        pixel_clock_pin_in,
  output reg         pixel_clock_pin_out,
  output wire        pixel_clock_pin_oe,
  input  wire        line_sync_pin_in,
  output reg         line_sync_pin_out,
  output wire        line_sync_pin_oe,
  input  wire        frame_sync_pin_in,
  output reg         frame_sync_pin_out,
  output wire        frame_sync_pin_oe,
  input  wire        global_power_down,
  output reg         unit_powered_down,
  output reg         stream_byte_strobe,
  output reg  [1:0]  clock_source,
  output wire        irq
);
  // control, status and address phase state
  reg [31:0] ctrl_r;
  reg [11:0] line_match_register_r;
  reg [7:0]  mask_r;
  reg        line_match_flag_r;
  reg        underrun_flag_r;
  reg        first_buffer_drained_r;
  reg        second_buffer_drained_r;
  reg        buf_pend1_r;
  reg        buf_pend2_r;
  reg        active_buf2_r;
  reg [15:0] byte_cnt_r;
  reg        wr_pend_r;
  reg [7:0]  wr_addr_r;
  reg [2:0]  settle_r;
  reg [3:0]  div_cnt_r;
  reg        pin_prev_r;

  wire        swrst      = ctrl_r[`VOS_CTRL_SWRST];
  wire        keep_awake = ctrl_r[`VOS_CTRL_AWAKE];
  wire [1:0]  csel       = ctrl_r[`VOS_CTRL_CSEL_HI:`VOS_CTRL_CSEL_LO];
  wire [2:0]  pll_s      = ctrl_r[`VOS_CTRL_PLLS_HI:`VOS_CTRL_PLLS_LO];
  wire [2:0]  pll_t      = ctrl_r[`VOS_CTRL_PLLT_HI:`VOS_CTRL_PLLT_LO];
  wire        clk_drive  = ctrl_r[`VOS_CTRL_CLKDRV];
  wire        sync_mstr  = ctrl_r[`VOS_CTRL_SYNCM];
  wire [2:0]  mode       = ctrl_r[`VOS_CTRL_MODE_HI:`VOS_CTRL_MODE_LO];
  wire        unit_en    = ctrl_r[`VOS_CTRL_EN];
  wire        streaming  = (mode == `VOS_MODE_STREAM);
  wire        refresh    = (mode != 3'h0) & ~streaming;

  // ahb address phase decode
  wire        acc    = hsel & hready & htrans[1];
  wire        wr_now = wr_pend_r;
  wire        wr_ctl = wr_now & (wr_addr_r == `VOS_OFS_CTRL);
  wire        wr_st  = wr_now & (wr_addr_r == `VOS_OFS_STATUS);
  wire        ack1   = wr_ctl & hwdata[`VOS_CTRL_ACK1];
  wire        ack2   = wr_ctl & hwdata[`VOS_CTRL_ACK2];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // pixel clock divider ratio per source
  reg [3:0] div_sel;
  always @* begin
    case (csel)
      `VOS_CSEL_VCO:   div_sel = 4'h1;
      `VOS_CSEL_FBDIV: div_sel = {1'b0, pll_t} + 4'h1;
      `VOS_CSEL_INDIV: div_sel = {1'b0, pll_s} + 4'h1;
      `VOS_CSEL_DDS:   div_sel = DDS_DIV;
      default:         div_sel = DDS_DIV;
    endcase
  end

  // pixel enable from own divider or from an external pixel clock edge
  wire halted  = unit_powered_down;
  wire div_hit = (div_cnt_r >= div_sel - 4'h1);
  wire pix_en  = ~halted & (clk_drive ? (div_hit & ~pixel_clock_pin_out) : (pixel_clock_pin_in & ~pin_prev_r));

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_r           <= 4'h0;
      pixel_clock_pin_out <= 1'b0;
      pin_prev_r          <= 1'b0;
      clock_source        <= `VOS_CSEL_DDS;
    end else begin
      pin_prev_r   <= pixel_clock_pin_in;
      clock_source <= csel;
      if (!clk_drive || halted) begin
        div_cnt_r <= 4'h0;
      end else if (div_hit) begin
        div_cnt_r           <= 4'h0;
        pixel_clock_pin_out <= ~pixel_clock_pin_out;
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end

  // pins are inputs unless the drive controls are set
  assign pixel_clock_pin_oe = clk_drive;
  assign line_sync_pin_oe   = sync_mstr;
  assign frame_sync_pin_oe  = sync_mstr;

  // settling counter after software reset, counted in pixel clocks
  wire settled = (settle_r == `VOS_SETTLE_PIX);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_r <= `VOS_SETTLE_PIX;
    end else if (swrst) begin
      settle_r <= 3'h0;
    end else if (pix_en && !settled) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // the unit runs only once enabled and settled
  wire running = unit_en & settled & ~swrst;

  wire [11:0] line_cnt;
  wire        second_field_active;
  wire        vertical_blank_flag;
  wire        line_start;
  wire        sav_pulse;
  wire        field_end;
  wire        hs;
  wire        vs;

  vos_timing #(
    .H_TOTAL  (H_TOTAL),
    .H_ACTIVE (H_ACTIVE),
    .V_TOTAL  (V_TOTAL),
    .V_ACTIVE (V_ACTIVE)
  ) u_timing (
    .clk        (clk),
    .resetn     (resetn),
    .clr        (swrst),
    .run        (running & refresh),
    .pix_en     (pix_en),
    .line_cnt_r (line_cnt),
    .pix_cnt_r  (),
    .second_field_active_r   (second_field_active),
    .vertical_blank_flag_r   (vertical_blank_flag),
    .line_start (line_start),
    .sav_pulse  (sav_pulse),
    .field_end  (field_end),
    .hsync      (hs),
    .vsync      (vs)
  );

  // sync outputs and power state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_sync_pin_out  <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      unit_powered_down  <= 1'b0;
    end else begin
      line_sync_pin_out  <= refresh & hs;
      frame_sync_pin_out <= refresh & vs;
      unit_powered_down  <= global_power_down & ~keep_awake;
    end
  end

  // event detection
  wire line_hit    = refresh & line_start & ~vertical_blank_flag & (line_cnt == line_match_register_r);
  wire ref_underrun_flag    = refresh & sav_pulse & first_buffer_drained_r;
  wire step        = running & streaming & pix_en;
  wire last_byte   = step & (byte_cnt_r == BUF_SIZE - 1);
  wire next_ready  = active_buf2_r ? buf_pend1_r : buf_pend2_r;
  wire str_underrun_flag    = last_byte & ~next_ready;
  wire set_drain1  = (refresh & field_end) | (last_byte & ~active_buf2_r);
  wire set_drain2  = last_byte & active_buf2_r;
  wire clr_line    = wr_st & hwdata[`VOS_ST_LINE];
  wire clr_underrun_flag    = wr_st & hwdata[`VOS_ST_UNDERRUN_FLAG];

  // streaming byte counter and buffer switch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_cnt_r         <= 16'h0000;
      active_buf2_r      <= 1'b0;
      buf_pend1_r        <= 1'b0;
      buf_pend2_r        <= 1'b0;
      stream_byte_strobe <= 1'b0;
    end else if (swrst) begin
      byte_cnt_r         <= 16'h0000;
      active_buf2_r      <= 1'b0;
      buf_pend1_r        <= 1'b0;
      buf_pend2_r        <= 1'b0;
      stream_byte_strobe <= 1'b0;
    end else begin
      stream_byte_strobe <= step;
      if (last_byte) begin
        byte_cnt_r <= 16'h0000;
        if (next_ready) begin
          active_buf2_r <= ~active_buf2_r;
        end
      end else if (step) begin
        byte_cnt_r <= byte_cnt_r + 16'h0001;
      end
      // a pending buffer is consumed on the switch; an ack in the same cycle still counts
      buf_pend1_r <= ack1 | (buf_pend1_r & ~(last_byte & active_buf2_r & next_ready));
      buf_pend2_r <= ack2 | (buf_pend2_r & ~(last_byte & ~active_buf2_r & next_ready));
    end
  end

  // sticky flags, set wins over clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_match_flag_r       <= 1'b0;
      underrun_flag_r         <= 1'b0;
      first_buffer_drained_r  <= 1'b0;
      second_buffer_drained_r <= 1'b0;
    end else begin
      line_match_flag_r       <= line_hit | (line_match_flag_r & ~clr_line);
      underrun_flag_r         <= ref_underrun_flag | str_underrun_flag | (underrun_flag_r & ~clr_underrun_flag);
      first_buffer_drained_r  <= set_drain1 | (first_buffer_drained_r & ~ack1);
      second_buffer_drained_r <= set_drain2 | (second_buffer_drained_r & ~ack2);
    end
  end

  // live state bits of the status word
  wire field_flag = streaming ? active_buf2_r : (refresh & second_field_active & ~vertical_blank_flag);
  wire vb_flag    = refresh & vertical_blank_flag;

  wire [7:0] status = {vb_flag, field_flag, 1'b0, 1'b1, second_buffer_drained_r,
                       first_buffer_drained_r, underrun_flag_r, line_match_flag_r};

  // one level interrupt from all enabled flags
  assign irq = |(status[3:0] & mask_r[3:0]);

  // register writes in the data phase
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r                <= `VOS_CTRL_RESET;
      line_match_register_r <= 12'h000;
      mask_r                <= 8'h00;
      wr_pend_r             <= 1'b0;
      wr_addr_r             <= 8'h00;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr;
      if (wr_ctl) begin
        ctrl_r <= hwdata & `VOS_CTRL_WMASK;
      end
      if (wr_now && wr_addr_r == `VOS_OFS_LINE) begin
        line_match_register_r <= hwdata[11:0];
      end
      if (wr_now && wr_addr_r == `VOS_OFS_MASK) begin
        mask_r <= {4'h0, hwdata[3:0]};
      end
    end
  end

  // read data captured in the address phase, unmapped reads zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      case (haddr)
        `VOS_OFS_CTRL:   hrdata <= ctrl_r;
        `VOS_OFS_STATUS: hrdata <= {24'h00_0000, status};
        `VOS_OFS_LINE:   hrdata <= {20'h0_0000, line_match_register_r};
        `VOS_OFS_MASK:   hrdata <= {24'h00_0000, mask_r};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/vos_timing.v ***
// Purpose: field and line timing for video refresh
// Assumes: pix_en is a one-cycle enable per pixel
// Notes:   two interlaced fields, active lines first in each field
`timescale 1ns/1ps
`default_nettype none
module vos_timing #(
  parameter H_TOTAL  = 16,
  parameter H_ACTIVE = 12,
  parameter V_TOTAL  = 10,
  parameter V_ACTIVE = 8
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        clr,
  input  wire        run,
  input  wire        pix_en,
  output reg  [11:0] line_cnt_r,
  output reg  [11:0] pix_cnt_r,
  output reg         second_field_active_r,
  output reg         vertical_blank_flag_r,
  output wire        line_start,
  output wire        sav_pulse,
  output wire        field_end,
  output wire        hsync,
  output wire        vsync
);
  wire step     = run & pix_en;
  wire line_end = (pix_cnt_r == H_TOTAL - 1);
  wire last_ln  = (line_cnt_r == V_TOTAL - 1);

  // event pulses for the register block
  assign line_start = step & (pix_cnt_r == 12'h000);
  assign sav_pulse  = line_start & (line_cnt_r == 12'h000);
  assign field_end  = step & line_end & (line_cnt_r == V_ACTIVE - 1);
  assign hsync      = (pix_cnt_r >= H_ACTIVE);
  assign vsync      = vertical_blank_flag_r;

  // pixel, line and field counters
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pix_cnt_r  <= 12'h000;
      line_cnt_r <= 12'h000;
      second_field_active_r   <= 1'b0;
      vertical_blank_flag_r   <= 1'b0;
    end else if (clr) begin
      pix_cnt_r  <= 12'h000;
      line_cnt_r <= 12'h000;
      second_field_active_r   <= 1'b0;
      vertical_blank_flag_r   <= 1'b0;
    end else if (step) begin
      if (line_end) begin
        pix_cnt_r <= 12'h000;
        if (last_ln) begin
          line_cnt_r <= 12'h000;
          second_field_active_r   <= ~second_field_active_r;
          vertical_blank_flag_r   <= 1'b0;
        end else begin
          line_cnt_r <= line_cnt_r + 12'h001;
          vertical_blank_flag_r   <= (line_cnt_r >= V_ACTIVE - 1);
        end
      end else begin
        pix_cnt_r <= pix_cnt_r + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/vos_ctrl_bench.sv ***
// Purpose: self-checking bench for vos_ctrl
// Assumes: zero wait slave, partner makes the pixel clock
// Notes:   read expectations queued by the bus driver
`timescale 1ns/1ps
`default_nettype none
`include "vos_consts.vh"
`define VOS_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module vos_ctrl_bench;
  logic        clk, resetn, hsel, hwrite, gpd, rd_r, b;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, s, t;
  logic [31:0] hwdata, seed, word;
  logic [31:0] exp_q[$], msk_q[$];
  wire  [31:0] hrdata;
  wire  [1:0]  csrc;
  wire         hrdy, irq, pco, pcoe, lso, lsoe, fso, fsoe, upd, stb, pdrv, sdrv;
  wire         pin = pcoe ? pco : pdrv;
  int          miscompares, samples_checked, cycles, pixs, bytes, frames, n, p0, dv;
  vos_ctrl #(.BUF_SIZE(4)) i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata(hrdata),
    .pixel_clock_pin_in(pin), .pixel_clock_pin_out(pco), .pixel_clock_pin_oe(pcoe),
    .line_sync_pin_in(lsoe ? lso : sdrv), .line_sync_pin_out(lso), .line_sync_pin_oe(lsoe),
    .frame_sync_pin_in(fsoe ? fso : sdrv), .frame_sync_pin_out(fso), .frame_sync_pin_oe(fsoe),
    .global_power_down(gpd), .unit_powered_down(upd), .stream_byte_strobe(stb), .clock_source(csrc), .irq(irq));
  vos_video_sink #(.HALF(8)) i_sink (.clk(clk), .resetn(resetn), .pix_oe(pcoe), .frame_out(fso), .frame_oe(fsoe),
    .strobe(stb), .pix_drv(pdrv), .sync_drv(sdrv), .pix_cnt(pixs), .byte_cnt(bytes), .frame_cnt(frames));
  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one single transfer, held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  // two-step software reset, enable left low
  task automatic soft_reset(input logic [31:0] w);
    xfer(1'b1, `VOS_OFS_CTRL, w | 32'h8000_0000);
    rd(`VOS_OFS_CTRL, w | 32'h8000_0000, 32'hFFFF_FFFF);
    xfer(1'b1, `VOS_OFS_CTRL, w);
    p0 = pixs;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      end_sim();
    end
  end
  // read data against the oldest queued note
  always @(posedge clk) begin
    if (rd_r) begin
      `VOS_CHK("hrdata", exp_q[0], hrdata & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_r <= hsel && htrans[1] && !hwrite && hrdy;
  end
  initial begin
    {resetn, hsel, hwrite, gpd, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    seed = 32'h0aa2;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(`VOS_OFS_CTRL, `VOS_CTRL_RESET, 32'hFFFF_FFFF);
    `VOS_CHK("clock_source", 2'h3, csrc)
    `VOS_CHK("pin_enables", 3'b000, {pcoe, lsoe, fsoe})
    rd(`VOS_OFS_STATUS, 32'h0000_0010, 32'h0000_00DF);
    rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
    // every clock source, half period seen on the driven pin
    for (int c = 0; c < 4; c++) begin
      s = 3'($random(seed));
      t = 3'($random(seed));
      word = {2'b00, 2'(c), s, t, 2'b11, 20'h0_0000};
      xfer(1'b1, `VOS_OFS_CTRL, word);
      rd(`VOS_OFS_CTRL, word, 32'hFFFF_FFFF);
      `VOS_CHK("clock_source", 2'(c), csrc)
      dv = (c == 0) ? 1 : (c == 1) ? t + 1 : (c == 2) ? s + 1 : 2;
      b = pco;
      while (pco === b) @(posedge clk);
      b = pco;
      n = 0;
      while (pco === b && n < 40) begin
        @(posedge clk);
        n++;
      end
      `VOS_CHK("half_period", dv, n)
    end
    // power down with and without keep awake
    gpd <= 1'b1;
    xfer(1'b1, `VOS_OFS_CTRL, 32'h4000_0000);
    repeat (2) @(posedge clk);
    `VOS_CHK("powered_down", 1'b0, upd)
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `VOS_CHK("powered_down", 1'b1, upd)
    gpd <= 1'b0;
    // streaming: early enable held off, underrun, buffer switch
    soft_reset(32'h0010_0008);
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0010_0009);
    while (bytes == 0) @(posedge clk);
    `VOS_CHK("settle_pixels", 1'b1, pixs - p0 >= 5)
    while (bytes < 4) @(posedge clk);
    repeat (2) @(posedge clk);
    rd(`VOS_OFS_STATUS, 32'h0000_0006, 32'h0000_00C6);
    xfer(1'b1, `VOS_OFS_MASK, 32'h0000_0002);
    @(posedge clk);
    `VOS_CHK("irq", 1'b1, irq)
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0010_0109);
    rd(`VOS_OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0010_0209);
    xfer(1'b1, `VOS_OFS_STATUS, 32'h0000_0002);
    @(posedge clk);
    `VOS_CHK("irq", 1'b0, irq)
    while (bytes < 10) @(posedge clk);
    rd(`VOS_OFS_STATUS, 32'h0000_0040, 32'h0000_0042);
    // refresh: line match, unacked field underrun, blanking
    soft_reset(32'h0030_0002);
    xfer(1'b1, `VOS_OFS_STATUS, 32'h0000_000F);
    xfer(1'b1, `VOS_OFS_LINE, 32'h0000_0003);
    xfer(1'b1, `VOS_OFS_MASK, 32'h0000_0001);
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0030_0003);
    n = frames;
    while (frames < n + 2) @(posedge clk);
    rd(`VOS_OFS_STATUS, 32'h0000_0083, 32'h0000_0083);
    `VOS_CHK("irq", 1'b1, irq)
    xfer(1'b1, `VOS_OFS_STATUS, 32'h0000_0003);
    xfer(1'b1, `VOS_OFS_CTRL, 32'h0030_0103);
    @(posedge clk);
    `VOS_CHK("irq", 1'b0, irq)
    n = frames;
    while (frames < n + 1) @(posedge clk);
    rd(`VOS_OFS_STATUS, 32'h0000_0081, 32'h0000_0083);
    // next field is field two, seen once blanking ends
    while (fso !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
    rd(`VOS_OFS_STATUS, 32'h0000_0040, 32'h0000_00C0);
    xfer(1'b1, `VOS_OFS_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `VOS_CHK("irq", 1'b0, irq)
    end_sim();
  end
endmodule
`default_nettype wire

// *** verification/vos_ctrl_monitor.sv ***
// Purpose: port checker for vos_ctrl
// Assumes: one clock, writes land at the end of the data phase
// Notes:   shadows a few control fields from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "vos_consts.vh"
module vos_ctrl_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        pixel_clock_pin_in,
  input wire logic        pixel_clock_pin_oe,
  input wire logic        line_sync_pin_oe,
  input wire logic        frame_sync_pin_oe,
  input wire logic        frame_sync_pin_out,
  input wire logic        global_power_down,
  input wire logic        unit_powered_down,
  input wire logic        stream_byte_strobe,
  input wire logic [1:0]  clock_source,
  input wire logic        irq
);
  logic       wr_r, awake_r, rst_r, pin_r;
  logic [7:0] adr_r;
  logic [2:0] mode_r, settle_r;
  logic [1:0] age_r;
  wire        wr_ctl = wr_r && adr_r == `VOS_OFS_CTRL;
  wire        wr_msk = wr_r && adr_r == `VOS_OFS_MASK;
  wire        rise   = pixel_clock_pin_in && !pin_r && !pixel_clock_pin_oe;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow of write data phases and control fields
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r     <= 1'b0;
      adr_r    <= 8'h00;
      awake_r  <= 1'b0;
      mode_r   <= 3'h0;
      age_r    <= 2'h3;
      rst_r    <= 1'b0;
      settle_r <= 3'h7;
      pin_r    <= 1'b0;
    end else begin
      wr_r  <= hsel && hready && htrans[1] && hwrite;
      adr_r <= haddr;
      pin_r <= pixel_clock_pin_in;
      age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
      if (wr_ctl) begin
        awake_r <= hwdata[30];
        mode_r  <= hwdata[3:1];
        age_r   <= 2'h0;
        rst_r   <= hwdata[31];
      end
      if (wr_ctl && hwdata[31])
        settle_r <= 3'h0;
      else if (rise && !rst_r && settle_r != 3'h7)
        settle_r <= settle_r + 3'h1;
    end
  end
  AST_RST_PINS_IN: assert property ($rose(resetn) |-> !pixel_clock_pin_oe && !line_sync_pin_oe)
    else $error("pin enable set after reset");
  AST_RST_CLK_SEL: assert property ($rose(resetn) |-> clock_source == 2'h3)
    else $error("clock source not 3 after reset");
  AST_SYNC_OE_PAIR: assert property (line_sync_pin_oe == frame_sync_pin_oe)
    else $error("sync pin enables differ");
  AST_CLK_SEL_FOLLOW: assert property (wr_ctl |-> ##2 clock_source == $past(hwdata[29:28], 2))
    else $error("clock source not from control word");
  AST_AWAKE: assert property ($past(resetn) |-> unit_powered_down == $past(global_power_down && !awake_r))
    else $error("power down ignores keep awake");
  AST_MASK_OFF: assert property (wr_msk && hwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with all sources masked");
  AST_IRQ_HOLD: assert property (irq && !wr_r |=> irq)
    else $error("irq dropped without software clear");
  AST_VERTICAL_BLANK_FLAG_MODE: assert property (age_r == 2'h3 && (mode_r == 3'h0 || mode_r == 3'h4) |-> !frame_sync_pin_out)
    else $error("blanking outside refresh");
  AST_SETTLE: assert property (settle_r < 3'h5 && $past(settle_r) < 3'h5 |-> !stream_byte_strobe)
    else $error("data before five pixel clocks");
  cover property ($rose(irq));
  cover property (stream_byte_strobe);
  cover property ($rose(frame_sync_pin_out));
endmodule
bind vos_ctrl vos_ctrl_monitor i_mon (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .pixel_clock_pin_in(pixel_clock_pin_in),
  .pixel_clock_pin_oe(pixel_clock_pin_oe), .line_sync_pin_oe(line_sync_pin_oe), .frame_sync_pin_oe(frame_sync_pin_oe),
  .frame_sync_pin_out(frame_sync_pin_out), .global_power_down(global_power_down),
  .unit_powered_down(unit_powered_down), .stream_byte_strobe(stream_byte_strobe), .clock_source(clock_source),
  .irq(irq));
`default_nettype wire

// *** verification/vos_video_sink.sv ***
// Purpose: external video device model
// Assumes: pixel clock made here unless the unit drives it
// Notes:   counts pixels, bytes and frames for the bench
`timescale 1ns/1ps
`default_nettype none
module vos_video_sink #(
  parameter HALF = 8
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pix_oe,
  input  wire logic frame_out,
  input  wire logic frame_oe,
  input  wire logic strobe,
  output var  logic pix_drv,
  output var  logic sync_drv,
  output var  int   pix_cnt,
  output var  int   byte_cnt,
  output var  int   frame_cnt
);
  int   ph;
  logic fq;
  // free running pixel clock, released sync lines wander
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph        <= 0;
      fq        <= 1'b0;
      pix_drv   <= 1'b0;
      sync_drv  <= 1'b0;
      pix_cnt   <= 0;
      byte_cnt  <= 0;
      frame_cnt <= 0;
    end else begin
      sync_drv <= ~sync_drv;
      fq       <= frame_out;
      if (strobe)
        byte_cnt <= byte_cnt + 1;
      if (frame_oe && frame_out && !fq)
        frame_cnt <= frame_cnt + 1;
      if (ph == HALF - 1) begin
        ph      <= 0;
        pix_drv <= ~pix_drv;
        if (!pix_drv && !pix_oe)
          pix_cnt <= pix_cnt + 1;
      end else
        ph <= ph + 1;
    end
  end
endmodule
`default_nettype wire
